// *** design/aidr_pkg.sv ***
// How it works
// - interrupt source caught on rising edge, routed to bus line 2-7 by software
// - interrupt line driven only while interrupt enable is set
// - each interrupt event held in a flip-flop until software clears it
// - status read shows the interrupt flip-flop as the flag bit
// - a write to the control register clears the interrupt flip-flop unless an event sets it in that cycle
// - request and acknowledge go to DMA channel 1 or 3 by board strap
// - DMA requests raised only while DMA enable is set
// - block ends at controller terminal count, which raises the interrupt
// - with DMA enabled, two byte requests follow every conversion
// - result latched for DMA until the next conversion replaces it
// - low byte delivered first, then high byte
// - pacer timer has three 16-bit down-counters
// - two counters chained on 1 or 10 MHz form pacer; third is free
// - sixteen consecutive register slots from a configurable base
package aidr_pkg;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          TCLK_SLOW_HZ  = 1_000_000;
    localparam int          TCLK_FAST_HZ  = 10_000_000;
    localparam int          PRE_SLOW      = CLK_HZ / TCLK_SLOW_HZ;
    localparam int          PRE_FAST      = CLK_HZ / TCLK_FAST_HZ;
    localparam int          CONV_MAX_HZ   = 100_000;
    localparam int          CONV_CYCLES   = CLK_HZ / CONV_MAX_HZ;
    localparam int          SYNC_LAT      = 4;
    localparam int          REG_SLOTS     = 16;

    localparam logic [3:0]  IDX_CTRL      = 4'h0;
    localparam logic [3:0]  IDX_STATUS    = 4'h1;
    localparam logic [3:0]  IDX_RESULT    = 4'h2;
    localparam logic [3:0]  IDX_EV_STAT   = 4'h3;
    localparam logic [3:0]  IDX_EV_MASK   = 4'h4;
    localparam logic [3:0]  IDX_CTR0      = 4'h5;
    localparam logic [3:0]  IDX_CTR1      = 4'h6;
    localparam logic [3:0]  IDX_CTR2      = 4'h7;

    localparam int          CTRL_INT_EN   = 0;
    localparam int          CTRL_DMA_EN   = 1;
    localparam int          CTRL_LVL_LO   = 2;
    localparam int          CTRL_FAST     = 5;
    localparam int          ST_INT        = 0;
    localparam int          ST_DRQ        = 1;
    localparam int          ST_BPTR       = 2;
    localparam int          ST_CHAN3      = 3;
    localparam int          EV_CONV       = 0;
    localparam int          EV_TC         = 1;
    localparam int          EV_OVR        = 2;

    localparam int          SY_CONV       = 0;
    localparam int          SY_TC         = 1;
    localparam int          SY_DACK       = 2;
    localparam int          SY_C2CLK      = 3;
    localparam int          SY_CHAN       = 4;
    localparam int          SY_N          = 5;

    localparam logic [2:0]  LVL_MIN       = 3'h2;
    localparam logic [2:0]  LVL_RST       = 3'h2;
    localparam logic [15:0] CTR_RST       = 16'hFFFF;
endpackage

// *** design/aidr_down_ctr.sv ***
`timescale 1ns/1ps
`default_nettype none
module aidr_down_ctr
    import aidr_pkg::*;
#(
    parameter int W = 16
)(
    input  wire logic         clk,    // core clock
    input  wire logic         rst,    // sync reset
    input  wire logic         load,   // take reload value
    input  wire logic [W-1:0] reload, // reload value
    input  wire logic         tick,   // count enable pulse
    output logic      [W-1:0] count,  // current count
    output logic              wrap    // pulse on terminal count
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         wrap;
    } aidr_ctr_t;

    aidr_ctr_t q;
    aidr_ctr_t d;

    if (W < 2)
    begin : g_chk
        $error("counter width too small");
    end

    always_comb
    begin
        d      = q;
        d.wrap = 1'b0;
        if (load)
        begin
            d.cnt = reload;
        end
        else if (tick)
        begin
            if (q.cnt <= W'(1))
            begin
                d.cnt  = reload;
                d.wrap = 1'b1;
            end
            else
            begin
                d.cnt = q.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q.cnt  <= '1;
            q.wrap <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    assign count = q.cnt;
    assign wrap  = q.wrap;
endmodule
`default_nettype wire

// *** design/aidr_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module aidr_top
    import aidr_pkg::*;
#(
    parameter logic [11:0] BASE_ADDR = 12'h000,
    parameter int          CTR_W     = 16
)(
    input  wire logic        core_clk,    // 10 MHz
    input  wire logic        rst,         // sync, active high
    input  wire logic        psel,        // apb select
    input  wire logic        penable,     // apb enable
    input  wire logic        pwrite,      // apb direction
    input  wire logic [11:0] paddr,       // apb byte address
    input  wire logic [31:0] pwdata,      // apb write data
    output logic      [31:0] prdata,      // apb read data
    output logic             pready,      // apb ready
    output logic             pslverr,     // apb error
    input  wire logic        conv_done,   // a/d end of conversion, pin
    input  wire logic [15:0] conv_data,   // a/d result, stable after eoc
    input  wire logic        dma_tc,      // controller terminal count, pin
    input  wire logic        dack_n,      // dma acknowledge, pin
    input  wire logic        chan3_strap, // board switch: 1 selects ch 3
    input  wire logic        ctr2_clk,    // user counter clock, pin
    output logic             drq1,        // dma request ch 1
    output logic             drq3,        // dma request ch 3
    output logic      [7:0]  dma_data,    // byte on dma read
    output logic      [5:0]  irq_line,    // bus lines 2..7
    output logic             irq,         // masked event interrupt
    output logic             pacer_trig,  // conversion start pulse
    output logic             ctr2_out     // user counter terminal pulse
);
    if (CTR_W != 16)
    begin : g_chk
        $error("pacer counters must be 16 bits");
    end

    // two acknowledges per result, each low and high through the filter
    if (CONV_CYCLES < 4 * SYNC_LAT)
    begin : g_rate
        $error("core clock too slow for the conversion rate");
    end

    typedef struct packed {
        logic [SY_N-1:0]  sa;
        logic [SY_N-1:0]  sb;
        logic [SY_N-1:0]  sc;
        logic [SY_N-1:0]  filt;
        logic             int_en;
        logic             dma_en;
        logic             fast;
        logic [2:0]       lvl;
        logic             int_ff;
        logic [2:0]       ev;
        logic [2:0]       mask;
        logic [15:0]      result;
        logic             drq;
        logic             bptr;
        logic [7:0]       dma_data;
        logic [15:0]      rl0;
        logic [15:0]      rl1;
        logic [15:0]      rl2;
        logic [2:0]       ld;
        logic [3:0]       pre;
        logic             pacer;
        logic             c2out;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
        logic             irq;
        logic [5:0]       irq_line;
        logic             drq1;
        logic             drq3;
    } aidr_st_t;

    aidr_st_t q;
    aidr_st_t d;

    logic [15:0] cnt0;
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic        wrap0;
    logic        wrap1;
    logic        wrap2;
    logic        tick0;
    logic        tick2;

    // pacer: counter 0 on timer clock, counter 1 on counter 0 wrap
    aidr_down_ctr #(.W(CTR_W)) u_ctr0 (
        .clk    (core_clk),
        .rst    (rst),
        .load   (q.ld[0]),
        .reload (q.rl0),
        .tick   (tick0),
        .count  (cnt0),
        .wrap   (wrap0)
    );
    aidr_down_ctr #(.W(CTR_W)) u_ctr1 (
        .clk    (core_clk),
        .rst    (rst),
        .load   (q.ld[1]),
        .reload (q.rl1),
        .tick   (wrap0),
        .count  (cnt1),
        .wrap   (wrap1)
    );
    aidr_down_ctr #(.W(CTR_W)) u_ctr2 (
        .clk    (core_clk),
        .rst    (rst),
        .load   (q.ld[2]),
        .reload (q.rl2),
        .tick   (tick2),
        .count  (cnt2),
        .wrap   (wrap2)
    );

    logic [SY_N-1:0] filt_d;
    logic            conv_ev;
    logic            tc_ev;
    logic            dack_ev;
    logic            in_win;
    logic [3:0]      idx;
    logic            setup;
    logic            acc;
    logic            wr;
    logic [3:0]      pre_max;

    always_comb
    begin
        filt_d  = q.filt;
        for (int i = 0; i < SY_N; i++)
        begin
            if (q.sb[i] == q.sc[i])
            begin
                filt_d[i] = q.sc[i];
            end
        end
        conv_ev = filt_d[SY_CONV] & ~q.filt[SY_CONV];
        tc_ev   = filt_d[SY_TC] & ~q.filt[SY_TC];
        dack_ev = filt_d[SY_DACK] & ~q.filt[SY_DACK];
        tick2   = ~filt_d[SY_C2CLK] & q.filt[SY_C2CLK]; // falling edge counts
        pre_max = q.fast ? 4'(PRE_FAST - 1) : 4'(PRE_SLOW - 1);
        tick0   = (q.pre == pre_max);
        in_win  = (paddr[11:6] == BASE_ADDR[11:6]);
        idx     = paddr[5:2];
        setup   = psel & ~penable & ~q.pready;
        acc     = psel & penable & q.pready;
        wr      = acc & pwrite & in_win;
    end

    always_comb
    begin
        d      = q;
        d.sa   = {chan3_strap, ctr2_clk, ~dack_n, dma_tc, conv_done};
        d.sb   = q.sa;
        d.sc   = q.sb;
        d.filt = filt_d;
        d.ld   = 3'h0;
        d.pre  = tick0 ? 4'h0 : q.pre + 4'h1;
        d.pacer = wrap1;
        d.c2out = wrap2;

        // apb: answer registered at setup, one access cycle
        d.pready  = setup;
        d.pslverr = 1'b0;
        if (setup)
        begin
            d.prdata  = 32'h0000_0000;
            d.pslverr = ~in_win;
            if (in_win)
            begin
                unique case (idx)
                    IDX_CTRL:
                        d.prdata[5:0] = {q.fast, q.lvl, q.dma_en, q.int_en};
                    IDX_STATUS:
                        d.prdata[3:0] = {q.filt[SY_CHAN], q.bptr, q.drq, q.int_ff};
                    IDX_RESULT:  d.prdata[15:0] = q.result;
                    IDX_EV_STAT: d.prdata[2:0]  = q.ev;
                    IDX_EV_MASK: d.prdata[2:0]  = q.mask;
                    IDX_CTR0:    d.prdata[15:0] = cnt0;
                    IDX_CTR1:    d.prdata[15:0] = cnt1;
                    IDX_CTR2:    d.prdata[15:0] = cnt2;
                    default:     d.pslverr = 1'b1;
                endcase
            end
        end

        if (wr)
        begin
            unique case (idx)
                IDX_CTRL:
                begin
                    d.int_en = pwdata[CTRL_INT_EN];
                    d.dma_en = pwdata[CTRL_DMA_EN];
                    d.lvl    = pwdata[CTRL_LVL_LO +: 3];
                    d.fast   = pwdata[CTRL_FAST];
                    d.int_ff = 1'b0;
                end
                IDX_EV_STAT: d.ev   = q.ev & ~pwdata[2:0];
                IDX_EV_MASK: d.mask = pwdata[2:0];
                IDX_CTR0:
                begin
                    d.rl0   = pwdata[15:0];
                    d.ld[0] = 1'b1;
                end
                IDX_CTR1:
                begin
                    d.rl1   = pwdata[15:0];
                    d.ld[1] = 1'b1;
                end
                IDX_CTR2:
                begin
                    d.rl2   = pwdata[15:0];
                    d.ld[2] = 1'b1;
                end
                default: ;
            endcase
        end

        // interrupt flop: set beats the clearing write
        if (conv_ev | tc_ev)
        begin
            d.int_ff = 1'b1;
        end
        if (conv_ev)
        begin
            d.ev[EV_CONV] = 1'b1;
        end
        if (tc_ev)
        begin
            d.ev[EV_TC] = 1'b1;
        end

        // dma: latch result, request two bytes, low first
        if (dack_ev & q.drq)
        begin
            if (!q.bptr)
            begin
                d.bptr     = 1'b1;
                d.dma_data = q.result[15:8];
            end
            else
            begin
                d.drq  = 1'b0;
                d.bptr = 1'b0;
            end
        end
        if (conv_ev)
        begin
            d.result = conv_data;
            if (q.drq)
            begin
                d.ev[EV_OVR] = 1'b1;
            end
            d.drq      = d.dma_en;
            d.bptr     = 1'b0;
            d.dma_data = conv_data[7:0];
        end
        if (!d.dma_en)
        begin
            d.drq = 1'b0;
        end

        d.drq1 = d.drq & ~d.filt[SY_CHAN];
        d.drq3 = d.drq & d.filt[SY_CHAN];
        d.irq  = |(d.ev & d.mask);
        d.irq_line = 6'h00;
        if (d.int_en && d.int_ff && d.lvl >= LVL_MIN)
        begin
            d.irq_line[d.lvl - LVL_MIN] = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            q     <= '0;
            q.lvl <= LVL_RST;
            q.rl0 <= CTR_RST;
            q.rl1 <= CTR_RST;
            q.rl2 <= CTR_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign prdata     = q.prdata;
    assign pready     = q.pready;
    assign pslverr    = q.pslverr;
    assign drq1       = q.drq1;
    assign drq3       = q.drq3;
    assign dma_data   = q.dma_data;
    assign irq_line   = q.irq_line;
    assign irq        = q.irq;
    assign pacer_trig = q.pacer;
    assign ctr2_out   = q.c2out;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_first_byte;
        q.drq && dack_ev && !q.bptr;
    endsequence

    a_line_needs_en: assert property (
        (irq_line != 6'h00) |-> q.int_en && q.int_ff)
        else $error("interrupt line without enable or flag");
    a_line_routed: assert property (
        q.int_en && q.int_ff && q.lvl >= LVL_MIN |-> irq_line[q.lvl - LVL_MIN] && $onehot(irq_line))
        else $error("interrupt not on the selected line");
    a_edge_sets_ff: assert property (
        (conv_ev || tc_ev) |=> q.int_ff)
        else $error("interrupt event not latched");
    a_ff_holds: assert property (
        q.int_ff && !wr |=> q.int_ff)
        else $error("interrupt flop dropped without a write");
    a_ctrl_clears: assert property (
        wr && idx == IDX_CTRL && !conv_ev && !tc_ev |=> !q.int_ff)
        else $error("control write did not clear flag");
    a_drq_needs_en: assert property (
        (drq1 || drq3) |-> q.dma_en)
        else $error("dma request while disabled");
    a_req_after_conv: assert property (
        conv_ev && q.dma_en && !wr |=> ##1 (drq1 || drq3))
        else $error("no dma request after conversion");
    a_byte_order: assert property (
        s_first_byte |=> q.bptr && dma_data == q.result[15:8])
        else $error("high byte not presented after low byte");
    a_drop_second: assert property (
        q.drq && q.bptr && dack_ev && !conv_ev |=> !q.drq ##1 !(drq1 || drq3))
        else $error("request held after second byte");
    a_one_channel: assert property (
        !(drq1 && drq3))
        else $error("both dma channels requested");
    a_result_latch: assert property (
        !conv_ev |=> $stable(q.result))
        else $error("result changed without a conversion");
endmodule
`default_nettype wire

// *** test/aidr_dma_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module aidr_dma_host (
    input  wire logic       core_clk, // bench clock
    input  wire logic       rst,      // sync reset
    input  wire logic       drq,      // request of the strapped channel
    input  wire logic       slow,     // late acknowledge
    input  wire logic [7:0] dma_data, // byte on the bus
    output logic            dack_n,   // acknowledge, active low
    output logic            dma_tc,   // terminal count
    output logic      [7:0] byte_q,   // byte taken
    output logic            byte_vld  // one cycle per byte taken
);
    int n_byte;

    initial
    begin
        dack_n   = 1'b1;
        dma_tc   = 1'b0;
        byte_q   = 8'h00;
        byte_vld = 1'b0;
        n_byte   = 0;
    end

    // channel already programmed by the host before device dma is enabled
    always
    begin
        @(posedge core_clk);
        if (!rst && drq)
        begin
            repeat (slow ? 7 : 1) @(posedge core_clk);
            byte_q   <= dma_data;
            byte_vld <= 1'b1;
            dack_n   <= 1'b0;
            n_byte   <= n_byte + 1;
            @(posedge core_clk);
            byte_vld <= 1'b0;
            repeat (4) @(posedge core_clk);
            // released high between bytes, then block ends after eight bytes
            dack_n   <= 1'b1;
            dma_tc   <= (n_byte == 8);
            repeat (5) @(posedge core_clk);
            dma_tc   <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** test/tb_aidr_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_aidr_top;
    logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        conv_done, dma_tc, dack_n, chan3_strap, slow, byte_vld;
    logic [15:0] conv_data, d;
    logic        drq1, drq3, irq;
    logic [7:0]  dma_data, byte_q;
    logic [5:0]  irq_line;
    logic [1:0]  seen;
    logic [32:0] e;
    logic [32:0] exp_rd[$];
    logic [7:0]  exp_dma[$];
    int          n_mismatch, checks, n;
    logic        ctr2_clk, ctr2_out, pacer_trig;
    int          n_c2 = 0;
    int          cyc_n = 0;
    int          last_p = 0;
    int          gap = 0;

    aidr_top i_aidr_top (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
        .conv_data(conv_data), .dma_tc(dma_tc), .dack_n(dack_n),
        .chan3_strap(chan3_strap), .ctr2_clk(ctr2_clk), .drq1(drq1), .drq3(drq3),
        .dma_data(dma_data), .irq_line(irq_line), .irq(irq),
        .pacer_trig(pacer_trig), .ctr2_out(ctr2_out)
    );

    aidr_dma_host i_aidr_dma_host (
        .core_clk(core_clk), .rst(rst), .drq(chan3_strap ? drq3 : drq1),
        .slow(slow), .dma_data(dma_data), .dack_n(dack_n), .dma_tc(dma_tc),
        .byte_q(byte_q), .byte_vld(byte_vld)
    );

    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, x, s);
        end
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int k;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
            n_mismatch++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] x);
        exp_rd.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic pulse();
        conv_done <= 1'b1;
        cyc(5);
        conv_done <= 1'b0;
        cyc(5);
    endtask

    // result monitor
    always @(posedge core_clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_rd.size() > 0)
        begin
            e = exp_rd.pop_front();
            chk("prdata", prdata, e[31:0]);
            chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
        end
        if (byte_vld && exp_dma.size() > 0)
            chk("dma_data", {24'h0, byte_q}, {24'h0, exp_dma.pop_front()});
        cyc_n <= cyc_n + 1;
        if (ctr2_out === 1'b1)
            n_c2 <= n_c2 + 1;
        if (pacer_trig === 1'b1)
        begin
            gap    <= cyc_n - last_p;
            last_p <= cyc_n;
        end
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        end_of_test();
    end

    initial
    begin
        rst = 1'b1;
        {psel, penable, pwrite, conv_done, chan3_strap, slow} = 6'h00;
        ctr2_clk = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        conv_data = 16'h0000;
        n_mismatch = 0;
        checks = 0;
        void'($urandom(79253));
        cyc(12);
        rst <= 1'b0;
        rd(12'h000, 33'h000000008);
        rd(12'h014, 33'h00000FFFF);
        rd(12'h020, 33'h100000000);
        for (int l = 2; l < 8; l++)
        begin
            wr(12'h000, 32'((l << 2) | 1));
            pulse();
            chk("irq_line", {26'h0, irq_line}, 32'(1 << (l - 2)));
            rd(12'h004, 33'h1);
            wr(12'h000, 32'((l << 2) | 1));
            cyc(3);
            chk("irq_line", {26'h0, irq_line}, 32'h0);
        end
        wr(12'h000, 32'h8);
        pulse();
        chk("irq_line", {26'h0, irq_line}, 32'h0);
        rd(12'h004, 33'h1);
        wr(12'h000, 32'h8);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(12'h010, 32'h1);
        cyc(3);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(12'h00C, 32'h1);
        cyc(3);
        chk("irq", {31'h0, irq}, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            chan3_strap <= k[0];
            slow <= k[1];
            wr(12'h000, 32'hA);
            cyc(6);
            d = 16'($urandom);
            conv_data <= d;
            exp_dma.push_back(d[7:0]);
            exp_dma.push_back(d[15:8]);
            seen = 2'b00;
            pulse();
            n = 0;
            while (exp_dma.size() > 0 && n < 400)
            begin
                @(posedge core_clk);
                if (drq1 || drq3)
                    seen = {drq3, drq1};
                n++;
            end
            chk("bytes_left", 32'(exp_dma.size()), 32'h0);
            chk("drq_chan", {30'h0, seen}, k[0] ? 32'h2 : 32'h1);
            cyc(8);
            chk("drq", {30'h0, drq3, drq1}, 32'h0);
            rd(12'h008, {17'h0, d});
        end
        cyc(12);
        rd(12'h00C, 33'h3);
        wr(12'h000, 32'h8);
        d = 16'($urandom);
        conv_data <= d;
        pulse();
        cyc(5);
        chk("drq", {30'h0, drq3, drq1}, 32'h0);
        rd(12'h008, {17'h0, d});
        // free counter: reload 3, six falling edges give two wraps
        wr(12'h01C, 32'h3);
        repeat (6)
        begin
            ctr2_clk <= 1'b1;
            cyc(6);
            ctr2_clk <= 1'b0;
            cyc(6);
        end
        cyc(4);
        chk("ctr2_wraps", 32'(n_c2), 32'h2);
        rd(12'h01C, 33'h3);
        // fast timer clock, pacer period is the product of both reloads
        wr(12'h000, 32'h28);
        wr(12'h014, 32'h2);
        wr(12'h018, 32'h3);
        cyc(40);
        chk("pacer_gap", 32'(gap), 32'(2 * 3 * aidr_pkg::PRE_FAST));
        cyc(2);
        end_of_test();
    end
endmodule
`default_nettype wire
